// File: design/plhd_pkg.sv
package plhd_pkg;
  // Register byte offsets
  localparam logic [7:0] CTRL_OFS      = 8'h00;
  localparam logic [7:0] LOCK_CNT_OFS  = 8'h04;
  localparam logic [7:0] WINDOW_OFS    = 8'h08;
  localparam logic [7:0] DAC_OFS       = 8'h0C;
  localparam logic [7:0] EXIT_CNT_OFS  = 8'h10;
  localparam logic [7:0] STATUS_OFS    = 8'h14;
  localparam logic [7:0] IRQ_STAT_OFS  = 8'h18;
  localparam logic [7:0] IRQ_MASK_OFS  = 8'h1C;
  // Control field positions
  localparam int CTRL_MODE_LSB   = 0;
  localparam int CTRL_TRACK_BIT  = 2;
  localparam int CTRL_FIXED_BIT  = 3;
  localparam int CTRL_INHIBIT_BIT = 4;
  // Widths
  localparam int CNT_W   = 16;
  localparam int PHASE_W = 16;
  localparam int DAC_W   = 10;
  // Interrupt bit positions
  localparam int IRQ_LOCK_BIT    = 0;
  localparam int IRQ_UNLOCK_BIT  = 1;
  localparam int IRQ_HO_IN_BIT   = 2;
  localparam int IRQ_HO_OUT_BIT  = 3;
  localparam int IRQ_W           = 4;
  // Values
  localparam logic [1:0]         HOLDOVER_ON_MODE = 2'h2;
  localparam logic [1:0]         MODE_RST         = 2'h0;
  localparam logic [CNT_W-1:0]   LOCK_CNT_RST     = 16'h2710;
  localparam logic [PHASE_W-1:0] WINDOW_RST       = 16'h0010;
  localparam logic [CNT_W-1:0]   EXIT_CNT_RST     = 16'h0400;
  localparam logic [DAC_W-1:0]   DAC_MID          = 10'h200;
  // Holdover states
  typedef enum logic [1:0] {
    PLHD_TRACK   = 2'b00,
    PLHD_HOLD    = 2'b01,
    PLHD_RELOCK  = 2'b10
  } plhd_state_e;
endpackage

// File: design/plhd_lock_holdover.sv
// Contract
// [RULE1] Lock indicator rises only after phase stays in window for lock count.
// [RULE2] Lock indicator drops whenever phase error exceeds window, even after lock.
// [RULE3] With inhibit bit 0, a falling lock indicator enters holdover.
// [RULE4] Holdover exits when exit criteria met with valid reference; loop then relocks.
// [RULE5] Software should program a large lock count to avoid holdover cycling.
// [RULE6] Holdover selection value 2 enables holdover operation.
// [RULE7] Tracking disabled means tuning voltage is not tracked into holdover DAC.
// [RULE8] Fixed DAC select 1 drives holdover tuning from programmed fixed value.
// [RULE9] Fixed DAC code 512 gives roughly half supply tuning voltage.
// [RULE10] Exit frequency accuracy before leaving holdover is programmable.
// [RULE11] Fixed DAC code is unsigned, linear over tuning range, mid-scale near half.
`timescale 1ns/1ps
module plhd_lock_holdover (
  input  wire logic                        hclk,
  input  wire logic                        hresetn,
  input  wire logic                        hsel,
  input  wire logic [31:0]                 haddr,
  input  wire logic [1:0]                  htrans,
  input  wire logic                        hwrite,
  input  wire logic [2:0]                  hsize,
  input  wire logic [31:0]                 hwdata,
  input  wire logic                        hready,
  output logic                             hreadyout,
  output logic                             hresp,
  output logic [31:0]                      hrdata,
  input  wire logic                        pd_strobe,
  input  wire logic [plhd_pkg::PHASE_W-1:0] pd_phase_err,
  input  wire logic [plhd_pkg::DAC_W-1:0]  tune_sample,
  input  wire logic                        ref_valid,
  output logic                             lock_indicator,
  output logic                             holdover_active,
  output logic [plhd_pkg::DAC_W-1:0]       tune_dac_code,
  output logic                             irq
);
  localparam int CW = plhd_pkg::CNT_W;
  localparam int DW = plhd_pkg::DAC_W;
  localparam int PW = plhd_pkg::PHASE_W;
  localparam int IW = plhd_pkg::IRQ_W;

  logic [4:0]    ctrl_q;
  logic [CW-1:0] lock_count_threshold_q;
  logic [PW-1:0] phase_window_size_q;
  logic [DW-1:0] fixed_dac_value_q;
  logic [CW-1:0] exit_count_q;
  logic [IW-1:0] irq_stat_q;
  logic [IW-1:0] irq_mask_q;
  logic [IW-1:0] irq_evt;
  logic [CW-1:0] win_cnt_q;
  logic [CW-1:0] exit_cnt_q;
  logic          lock_q;
  logic          lock_d;
  logic [DW-1:0] tracked_q;
  logic [DW-1:0] dac_d;
  logic          ref_meta_q;
  logic          ref_sync_q;
  logic          in_window;
  logic          ho_enter;
  logic          ho_exit;
  logic          wr_pend_q;
  logic [7:0]    wr_addr_q;
  logic          wr_en;
  plhd_pkg::plhd_state_e state_q;
  plhd_pkg::plhd_state_e state_d;

  // Magnitude of a two's complement phase error
  function automatic logic [PW-1:0] abs_err(input logic [PW-1:0] e);
    abs_err = e[PW-1] ? PW'(-e) : e;
  endfunction

  // Decoded control bits
  wire logic [1:0] holdover_mode = ctrl_q[plhd_pkg::CTRL_MODE_LSB +: 2];
  wire logic en_track = ctrl_q[plhd_pkg::CTRL_TRACK_BIT];
  wire logic fixed_dac_select = ctrl_q[plhd_pkg::CTRL_FIXED_BIT];
  wire logic lock_loss_holdover_inhibit = ctrl_q[plhd_pkg::CTRL_INHIBIT_BIT];

  // Zero wait state slave, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  wire logic addr_phase = hsel & hready & htrans[1];

  // Reference valid pin, two flops before use
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ref_meta_q <= 1'b0;
      ref_sync_q <= 1'b0;
    end
    else
    begin
      ref_meta_q <= ref_valid;
      ref_sync_q <= ref_meta_q;
    end
  end

  // Write captured in address phase, applied in data phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end
    else
    begin
      wr_pend_q <= addr_phase & hwrite;
      wr_addr_q <= haddr[7:0];
    end
  end
  assign wr_en = wr_pend_q;

  // Configuration registers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl_q                 <= {3'h0, plhd_pkg::MODE_RST};
      lock_count_threshold_q <= plhd_pkg::LOCK_CNT_RST;
      phase_window_size_q    <= plhd_pkg::WINDOW_RST;
      fixed_dac_value_q      <= plhd_pkg::DAC_MID;  // Mid-scale [RULE9]
      exit_count_q           <= plhd_pkg::EXIT_CNT_RST;
      irq_mask_q             <= 4'h0;
    end
    else if (wr_en)
    begin
      if (wr_addr_q == plhd_pkg::CTRL_OFS)
        ctrl_q <= hwdata[4:0];
      else if (wr_addr_q == plhd_pkg::LOCK_CNT_OFS)
        lock_count_threshold_q <= hwdata[CW-1:0];
      else if (wr_addr_q == plhd_pkg::WINDOW_OFS)
        phase_window_size_q <= hwdata[PW-1:0];
      else if (wr_addr_q == plhd_pkg::DAC_OFS)
        fixed_dac_value_q <= hwdata[DW-1:0];  // Unsigned linear code [RULE11]
      else if (wr_addr_q == plhd_pkg::EXIT_CNT_OFS)
        exit_count_q <= hwdata[CW-1:0];  // Exit accuracy qualifier [RULE10]
      else if (wr_addr_q == plhd_pkg::IRQ_MASK_OFS)
        irq_mask_q <= hwdata[IW-1:0];
    end
  end

  // Read data registered in address phase; unmapped reads zero
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h0000_0000;
    else if (addr_phase & ~hwrite)
    begin
      if (haddr[7:0] == plhd_pkg::CTRL_OFS)
        hrdata <= {27'h0, ctrl_q};
      else if (haddr[7:0] == plhd_pkg::LOCK_CNT_OFS)
        hrdata <= {16'h0, lock_count_threshold_q};
      else if (haddr[7:0] == plhd_pkg::WINDOW_OFS)
        hrdata <= {16'h0, phase_window_size_q};
      else if (haddr[7:0] == plhd_pkg::DAC_OFS)
        hrdata <= {22'h0, fixed_dac_value_q};
      else if (haddr[7:0] == plhd_pkg::EXIT_CNT_OFS)
        hrdata <= {16'h0, exit_count_q};
      else if (haddr[7:0] == plhd_pkg::STATUS_OFS)
        hrdata <= {16'h0, 2'h0, tune_dac_code, state_q, holdover_active, lock_indicator};
      else if (haddr[7:0] == plhd_pkg::IRQ_STAT_OFS)
        hrdata <= {28'h0, irq_stat_q};
      else if (haddr[7:0] == plhd_pkg::IRQ_MASK_OFS)
        hrdata <= {28'h0, irq_mask_q};
      else
        hrdata <= 32'h0000_0000;
    end
  end

  // Lock detector: consecutive in-window comparisons
  assign in_window = abs_err(pd_phase_err) <= phase_window_size_q;
  always_comb
  begin
    lock_d = lock_q;
    if (pd_strobe)
    begin
      if (!in_window)
        lock_d = 1'b0;  // Any excursion drops lock [RULE2]
      else if (win_cnt_q >= lock_count_threshold_q)
        lock_d = 1'b1;  // Window held long enough [RULE1]
    end
  end

  // Counter saturates so a long lock cannot wrap and glitch
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      win_cnt_q <= 16'h0000;
      lock_q    <= 1'b0;
    end
    else
    begin
      lock_q <= lock_d;
      if (pd_strobe)
      begin
        if (!in_window)
          win_cnt_q <= 16'h0000;  // [RULE2]
        else if (win_cnt_q != 16'hFFFF)
          win_cnt_q <= win_cnt_q + 16'h0001;  // [RULE1]
      end
    end
  end
  assign lock_indicator = lock_q;

  // Holdover entry on falling lock; low count here risks chatter
  assign ho_enter = (state_q != plhd_pkg::PLHD_HOLD) && lock_q && !lock_d
                    && !lock_loss_holdover_inhibit  // [RULE3] [RULE5]
                    && (holdover_mode == plhd_pkg::HOLDOVER_ON_MODE);  // [RULE6]
  // A lock loss in the exit cycle keeps holdover when the inhibit bit is 0 and mode is 2, or the loop would reopen on a bad phase
  assign ho_exit = (state_q == plhd_pkg::PLHD_HOLD) && ref_sync_q
                   && pd_strobe && (exit_cnt_q >= exit_count_q)  // [RULE4] [RULE10]
                   && !(lock_q && !lock_d && !lock_loss_holdover_inhibit
                   && (holdover_mode == plhd_pkg::HOLDOVER_ON_MODE));  // [RULE3]

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      plhd_pkg::PLHD_TRACK:
        if (ho_enter)
          state_d = plhd_pkg::PLHD_HOLD;
      plhd_pkg::PLHD_HOLD:
        if (ho_exit)
          state_d = plhd_pkg::PLHD_RELOCK;  // Loop closes and relocks [RULE4]
      plhd_pkg::PLHD_RELOCK:
        if (ho_enter)
          state_d = plhd_pkg::PLHD_HOLD;
        else if (lock_q)
          state_d = plhd_pkg::PLHD_TRACK;
      default:
        state_d = plhd_pkg::PLHD_TRACK;
    endcase
  end

  // State and exit qualification counter
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_q    <= plhd_pkg::PLHD_TRACK;
      exit_cnt_q <= 16'h0000;
    end
    else
    begin
      state_q <= state_d;
      if (state_q != plhd_pkg::PLHD_HOLD || !ref_sync_q)
        exit_cnt_q <= 16'h0000;  // Lost reference restarts qualification
      else if (pd_strobe && exit_cnt_q != 16'hFFFF)
        exit_cnt_q <= exit_cnt_q + 16'h0001;  // [RULE10]
    end
  end
  assign holdover_active = (state_q == plhd_pkg::PLHD_HOLD);

  // Tuning voltage tracking, frozen in holdover
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      tracked_q <= plhd_pkg::DAC_MID;
    else if (en_track && state_d != plhd_pkg::PLHD_HOLD)
      tracked_q <= tune_sample;  // Only when enabled [RULE7]
  end

  // DAC code: closed loop passes the sample through
  always_comb
  begin
    if (state_d == plhd_pkg::PLHD_HOLD)
      dac_d = fixed_dac_select ? fixed_dac_value_q : tracked_q;  // [RULE8] [RULE11]
    else
      dac_d = tune_sample;
  end
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      tune_dac_code <= plhd_pkg::DAC_MID;  // [RULE9]
    else
      tune_dac_code <= dac_d;
  end

  // Sticky events; set wins over write-one-to-clear
  assign irq_evt = {ho_exit, ho_enter, lock_q & ~lock_d, ~lock_q & lock_d};
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      irq_stat_q <= 4'h0;
    else if (wr_en && wr_addr_q == plhd_pkg::IRQ_STAT_OFS)
      irq_stat_q <= (irq_stat_q & ~hwdata[IW-1:0]) | irq_evt;
    else
      irq_stat_q <= irq_stat_q | irq_evt;
  end
  assign irq = |(irq_stat_q & irq_mask_q);

  // Assertions
  a_lock_needs_count: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(lock_q) |-> $past(win_cnt_q) >= $past(lock_count_threshold_q) && $past(pd_strobe))
    else $error("lock rose before count reached");  // [RULE1]
  a_lock_drop_excursion: assert property (@(posedge hclk) disable iff (!hresetn)
    pd_strobe && !in_window |=> !lock_indicator && win_cnt_q == 16'h0000)
    else $error("lock held after window excursion");  // [RULE2]
  a_enter_on_loss: assert property (@(posedge hclk) disable iff (!hresetn)
    lock_q && !lock_d && !lock_loss_holdover_inhibit
    && holdover_mode == plhd_pkg::HOLDOVER_ON_MODE |=> holdover_active)
    else $error("holdover not entered on lock loss");  // [RULE3]
  a_exit_relock: assert property (@(posedge hclk) disable iff (!hresetn)
    $fell(holdover_active) |-> $past(ref_sync_q) && state_q == plhd_pkg::PLHD_RELOCK)
    else $error("holdover left without valid reference");  // [RULE4]
  a_mode_gates_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(holdover_active) |-> $past(holdover_mode) == plhd_pkg::HOLDOVER_ON_MODE)
    else $error("holdover entered while not enabled");  // [RULE6]
  a_no_track_frozen: assert property (@(posedge hclk) disable iff (!hresetn)
    !en_track |=> $stable(tracked_q))
    else $error("tracked value moved with tracking off");  // [RULE7]
  a_fixed_dac_out: assert property (@(posedge hclk) disable iff (!hresetn)
    holdover_active && fixed_dac_select ##1 holdover_active
    |-> tune_dac_code == $past(fixed_dac_value_q))
    else $error("holdover DAC not fixed value");  // [RULE8]
  a_dac_mid_reset: assert property (@(posedge hclk)
    !hresetn |=> tune_dac_code == 10'h200 || hresetn)
    else $error("DAC not mid-scale after reset");  // [RULE9]
  a_exit_accuracy: assert property (@(posedge hclk) disable iff (!hresetn)
    ho_exit |-> exit_cnt_q >= exit_count_q ##1 !holdover_active)
    else $error("holdover exit before accuracy count");  // [RULE10]
endmodule

// File: dv/plhd_far_end.sv
`timescale 1ns/1ps
// Far side: phase detector, tracked tuning voltage and reference status
module plhd_far_end (
  input  wire logic                          hclk,
  input  wire logic                          ref_ok,
  output logic                               pd_strobe,
  output logic [plhd_pkg::PHASE_W-1:0]       pd_phase_err,
  output logic [plhd_pkg::DAC_W-1:0]         tune_sample,
  output logic                               ref_valid
);
  // Tuning code keeps moving, so a frozen holdover value stands out
  always @(posedge hclk)
  begin
    tune_sample <= (tune_sample == 10'h155) ? 10'h2AA : 10'h155;
  end

  // Reference status pin, synchronised inside the block
  assign ref_valid = ref_ok;

  initial
  begin
    pd_strobe = 1'b0;
    pd_phase_err = 16'h0000;
    tune_sample = 10'h155;
  end

  // One comparison; the error bus is scrambled once it is no longer qualified
  task automatic strobe(input logic [plhd_pkg::PHASE_W-1:0] err);
    @(posedge hclk);
    pd_strobe <= 1'b1;
    pd_phase_err <= err;
    @(posedge hclk);
    pd_strobe <= 1'b0;
    pd_phase_err <= ~err;
    #1;
  endtask
endmodule

// File: dv/tb.sv
`timescale 1ns/1ps
module tb;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h0;
  logic [31:0] hwdata = 32'h0;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic        pd_strobe;
  logic [15:0] pd_phase_err;
  logic [9:0]  tune_sample;
  logic        ref_valid;
  logic        ref_ok = 1'b0;
  logic        lock_indicator;
  logic        holdover_active;
  logic [9:0]  tune_dac_code;
  logic        irq;
  int          n_mismatch = 0;
  int          samples_checked = 0;
  int          cyc = 0;

  always #2 hclk = ~hclk;

  plhd_far_end far (.hclk(hclk), .ref_ok(ref_ok), .pd_strobe(pd_strobe),
    .pd_phase_err(pd_phase_err), .tune_sample(tune_sample), .ref_valid(ref_valid));

  plhd_lock_holdover DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pd_strobe(pd_strobe),
    .pd_phase_err(pd_phase_err), .tune_sample(tune_sample), .ref_valid(ref_valid),
    .lock_indicator(lock_indicator), .holdover_active(holdover_active),
    .tune_dac_code(tune_dac_code), .irq(irq));

  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Hang guard, far above the couple of hundred cycles the run needs
  always @(posedge hclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      end_sim();
    end
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
      n_mismatch++;
    end
  endtask

  // Single AHB transfer: hold address phase, then data phase, until hready
  task automatic xfer(input logic [7:0] a, input logic wr, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= wr;
    hsize <= 3'h2;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(a, 1'b1, d, q);
  endtask

  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    xfer(a, 1'b0, 32'h0, q);
    chk(nm, exp, q);
  endtask

  task automatic lock_up();
    repeat (4) far.strobe(16'h0000);
    chk("lock", 32'h1, {31'h0, lock_indicator});
  endtask

  // In-window strobes with a valid reference until holdover ends, then relock
  task automatic recover();
    int n;
    n = 0;
    while (holdover_active !== 1'b0 && n < 8)
    begin
      far.strobe(16'h0000);
      n++;
    end
    chk("ho_exit", 32'h0, {31'h0, holdover_active});
    lock_up();
  endtask

  task automatic t_regs();
    rchk("ctrl", plhd_pkg::CTRL_OFS, 32'h0);
    rchk("lock_cnt", plhd_pkg::LOCK_CNT_OFS, 32'h2710);
    rchk("window", plhd_pkg::WINDOW_OFS, 32'h10);
    rchk("dac", plhd_pkg::DAC_OFS, 32'h200);
    rchk("exit_cnt", plhd_pkg::EXIT_CNT_OFS, 32'h400);
    rchk("unmapped", 8'h40, 32'h0);
    // Short lock count keeps the run brief; real systems want it large
    wr(plhd_pkg::LOCK_CNT_OFS, 32'h3);
    rchk("lock_cnt_wr", plhd_pkg::LOCK_CNT_OFS, 32'h3);
    wr(plhd_pkg::EXIT_CNT_OFS, 32'h2);
  endtask

  // Window edges +16 and -16 count as inside; lock on the fourth strobe
  task automatic t_lock();
    far.strobe(16'h0010);
    far.strobe(16'hFFF0);
    far.strobe(16'h0010);
    chk("lock_early", 32'h0, {31'h0, lock_indicator});
    lock_up();
  endtask

  // Lock loss with holdover off, then with the inhibit bit set
  task automatic t_nohold();
    far.strobe(16'h0011);
    chk("unlock", 32'h0, {31'h0, lock_indicator});
    chk("ho_mode0", 32'h0, {31'h0, holdover_active});
    lock_up();
    wr(plhd_pkg::CTRL_OFS, 32'h12);
    far.strobe(16'h0011);
    chk("ho_inhib", 32'h0, {31'h0, holdover_active});
    lock_up();
  endtask

  // No tracking, no fixed value: holdover keeps the reset tracked code
  task automatic t_track();
    wr(plhd_pkg::CTRL_OFS, 32'h2);
    far.strobe(16'h8000);
    chk("unlock_ho", 32'h0, {31'h0, lock_indicator});
    chk("ho_enter", 32'h1, {31'h0, holdover_active});
    chk("tune_frozen", 32'h200, {22'h0, tune_dac_code});
    repeat (4) far.strobe(16'h0000);
    chk("ho_noref", 32'h1, {31'h0, holdover_active});
    // Lock detector keeps counting in holdover, so lock is back by now
    rchk("status", plhd_pkg::STATUS_OFS, 32'h2007);
    @(posedge hclk);
    ref_ok <= 1'b1;
    repeat (3) @(posedge hclk);
    recover();
  endtask

  // Fixed DAC value drives the tuning code in holdover, full scale and mid
  task automatic t_fixed();
    logic [9:0] vals [2];
    vals = '{10'h3FF, 10'h200};
    wr(plhd_pkg::CTRL_OFS, 32'hA);
    foreach (vals[i])
    begin
      wr(plhd_pkg::DAC_OFS, {22'h0, vals[i]});
      far.strobe(16'h7FFF);
      chk("ho_fixed", 32'h1, {31'h0, holdover_active});
      chk("tune_fixed", {22'h0, vals[i]}, {22'h0, tune_dac_code});
      recover();
    end
  endtask

  // Tracking on: holdover keeps the last tracked sample while the input moves
  task automatic t_trk();
    logic [9:0] held;
    wr(plhd_pkg::CTRL_OFS, 32'h6);
    far.strobe(16'h7FFF);
    held = tune_sample;
    chk("ho_track", 32'h1, {31'h0, holdover_active});
    chk("tune_tracked", {22'h0, held}, {22'h0, tune_dac_code});
    repeat (3) @(posedge hclk);
    #1;
    chk("tune_held", {22'h0, held}, {22'h0, tune_dac_code});
    recover();
  endtask

  task automatic t_irq();
    wr(plhd_pkg::IRQ_MASK_OFS, 32'h0);
    chk("irq_masked", 32'h0, {31'h0, irq});
    rchk("irq_stat", plhd_pkg::IRQ_STAT_OFS, 32'hF);
    wr(plhd_pkg::IRQ_MASK_OFS, 32'h2);
    chk("irq_on", 32'h1, {31'h0, irq});
    wr(plhd_pkg::IRQ_STAT_OFS, 32'h2);
    rchk("irq_w1c", plhd_pkg::IRQ_STAT_OFS, 32'hD);
    chk("irq_off", 32'h0, {31'h0, irq});
  endtask

  initial
  begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs();
    t_lock();
    t_nohold();
    t_track();
    t_fixed();
    t_trk();
    t_irq();
    end_sim();
  end
endmodule
